/* File: tb/board_straps.sv */
`timescale 1ns/1ps
module board_straps (
	input wire       clk_i,
	output reg       pin_n_o,
	output reg [6:0] strap_o
);
	reg busy = 1'b0;
	initial pin_n_o = 1'b0;
	initial strap_o = 7'h00;
	// Straps wander outside a boot so a late sample shows up
	always @(posedge clk_i) if (!busy) #1 strap_o = ~strap_o;
	// Reference clock and spread spectrum are not modelled
	task boot(input [6:0] v);
		begin
			busy = 1'b1;
			@(posedge clk_i) #1 pin_n_o = 1'b0;
			repeat (10) @(posedge clk_i);
			#1 strap_o = v;
			@(posedge clk_i) #1 pin_n_o = 1'b1;
			repeat (6) @(posedge clk_i);
			busy = 1'b0;
		end
	endtask
endmodule // board_straps

/* File: tb/strap_capture_monitor.sv */
`timescale 1ns/1ps
module strap_capture_monitor #(parameter DS_PORTS = 3) (
	input wire               CLK_I,
	input wire               SYS_RST_I,
	input wire               FUNDAMENTAL_RESET_PIN_N_I,
	input wire               SW_HALT_CLR_I,
	input wire               SW_FUNDAMENTAL_RESET_REQUEST_BIT_I,
	input wire [6:0]         SWITCH_STATUS_O,
	input wire [DS_PORTS:0]  SLOT_CLOCK_CFG_O,
	input wire               HOLD_IN_RESET_CTL_O,
	input wire               CORE_RESET_O,
	input wire               SMBUS_MASTER_EN_O,
	input wire               EEPROM_LOAD_EN_O,
	input wire               MODE_RESERVED_O,
	input wire               AUX_POWER_EN_O
);
	wire [2:0] mode = SWITCH_STATUS_O[5:3];
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	sts_hold_a: assert property (
		$changed(SWITCH_STATUS_O) |-> FUNDAMENTAL_RESET_PIN_N_I
		&& !$past(FUNDAMENTAL_RESET_PIN_N_I, 8)) else $error("status moved");
	mode_rsv_a: assert property (
		!CORE_RESET_O |-> MODE_RESERVED_O == (mode > 3'h1)) else $error("reserved flag");
	load_mode_a: assert property (
		$rose(EEPROM_LOAD_EN_O) |-> mode == 3'h1 && CORE_RESET_O) else $error("load mode");
	halt_hold_a: assert property (
		HOLD_IN_RESET_CTL_O && !EEPROM_LOAD_EN_O |-> CORE_RESET_O && SMBUS_MASTER_EN_O)
		else $error("halt state");
	halt_exit_a: assert property (
		HOLD_IN_RESET_CTL_O && SW_HALT_CLR_I && !EEPROM_LOAD_EN_O |-> ##[1:8] !CORE_RESET_O)
		else $error("halt exit");
	warm_start_a: assert property (
		SW_FUNDAMENTAL_RESET_REQUEST_BIT_I && !CORE_RESET_O |-> ##[1:4] CORE_RESET_O) else $error("warm reset");
	slot_seed_a: assert property (
		$fell(CORE_RESET_O) && mode != 3'h1 |-> SLOT_CLOCK_CFG_O
		== {{DS_PORTS{SWITCH_STATUS_O[0]}}, SWITCH_STATUS_O[1]}) else $error("slot seed");
	aux_off_a: assert property (
		$fell(CORE_RESET_O) && mode != 3'h1 |-> AUX_POWER_EN_O == SWITCH_STATUS_O[6])
		else $error("aux power");
	cover property ($fell(HOLD_IN_RESET_CTL_O));
	cover property ($fell(EEPROM_LOAD_EN_O));
	cover property (SW_FUNDAMENTAL_RESET_REQUEST_BIT_I && !CORE_RESET_O);
endmodule // strap_capture_monitor
bind strap_capture strap_capture_monitor #(.DS_PORTS(DS_PORTS)) monitor_inst (.CLK_I,
	.SYS_RST_I, .FUNDAMENTAL_RESET_PIN_N_I, .SW_HALT_CLR_I, .SW_FUNDAMENTAL_RESET_REQUEST_BIT_I, .SWITCH_STATUS_O,
	.SLOT_CLOCK_CFG_O, .HOLD_IN_RESET_CTL_O, .CORE_RESET_O, .SMBUS_MASTER_EN_O,
	.EEPROM_LOAD_EN_O, .MODE_RESERVED_O, .AUX_POWER_EN_O);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         ee_wr = 1'b0, ee_done = 1'b0, clr = 1'b0, fundamental_reset_request_bit = 1'b0;
	reg  [3:0]  ee = 4'h0;
	reg         sw_wr = 1'b0;
	reg  [3:0]  sw_d = 4'h0;
	reg  [6:0]  v;
	reg  [13:0] exp_q[$];
	wire        pin_n, ctl, crst, smb, ld, rsv, aux, stk;
	wire [6:0]  strap, sts;
	wire [3:0]  slot;
	integer     bad_count = 0;
	integer     check_count = 0;
	integer     i;
	initial forever #2.5 clk = ~clk;
	board_straps board_straps_inst (.clk_i(clk), .pin_n_o(pin_n), .strap_o(strap));
	strap_capture #(.DS_PORTS(3), .WARM_RST_CYC(2)) strap_capture_inst (.CLK_I(clk),
		.SYS_RST_I(rst), .FUNDAMENTAL_RESET_PIN_N_I(pin_n),
		.COMMON_CLOCK_DOWNSTREAM_STRAP_I(strap[0]), .COMMON_CLOCK_UPSTREAM_STRAP_I(strap[1]),
		.HOLD_IN_RESET_STRAP_I(strap[2]), .SWITCH_OPERATING_MODE_STRAP_I(strap[5:3]),
		.AUX_POWER_DISABLE_STRAP_N_I(strap[6]), .EEPROM_WR_I(ee_wr), .EEPROM_CCLK_DS_I(ee[0]),
		.EEPROM_CCLK_US_I(ee[1]), .EEPROM_HALT_I(ee[2]), .EEPROM_APWR_N_I(ee[3]),
		.EEPROM_DONE_I(ee_done), .SW_HALT_CLR_I(clr), .SW_FUNDAMENTAL_RESET_REQUEST_BIT_I(fundamental_reset_request_bit), .SW_SCLK_WR_I(sw_wr),
		.SW_SCLK_DATA_I(sw_d), .SWITCH_STATUS_O(sts), .SLOT_CLOCK_CFG_O(slot),
		.HOLD_IN_RESET_CTL_O(ctl), .CORE_RESET_O(crst), .SMBUS_MASTER_EN_O(smb),
		.EEPROM_LOAD_EN_O(ld), .MODE_RESERVED_O(rsv), .AUX_POWER_EN_O(aux), .STICKY_CLEAR_O(stk));
	wire [13:0] seen = {sts, slot, aux, rsv, stk};
	task chk(input [13:0] e, input [13:0] s);
		begin
			check_count = check_count + 1;
			if (e !== s) begin
				bad_count = bad_count + 1;
				$display("ERROR outputs expected %h seen %h", e, s);
			end
		end
	endtask
	task give_verdict;
		begin
			if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	task automatic pulse(ref reg s);
		begin
			@(posedge clk) #1 s = 1'b1;
			@(posedge clk) #1 s = 1'b0;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic run(input [6:0] sv, input [3:0] e, input warm);
		reg [3:0] f;
		begin
			// Loader overrides all but the mode, status keeps the pin values
			f = (sv[5:3] == 3'h1) ? e : {sv[6], sv[2:0]};
			exp_q.push_back({sv, {3{f[0]}}, f[1], f[3], sv[5:3] > 3'h1, !f[3]});
			ee = e;
			if (warm) pulse(fundamental_reset_request_bit);
			else board_straps_inst.boot(sv);
			repeat (4) @(posedge clk);
			if (sv[5:3] == 3'h1) begin
				wait (ld);
				pulse(ee_wr);
				pulse(ee_done);
			end
			if (f[2]) begin
				repeat (20) @(posedge clk);
				chk(14'h7, {11'h0, crst, smb, ctl});
				pulse(clr);
			end
			wait (!crst);
			repeat (3) @(posedge clk);
			#1 sw_d = $urandom;
			pulse(sw_wr);
			chk({10'h0, sw_d}, {10'h0, slot});
		end
	endtask
	// Results appear when the core leaves reset
	always @(negedge crst) begin
		#1;
		chk(exp_q.pop_front(), seen);
	end
	initial begin
		void'($urandom(31686));
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			v = $urandom;
			if (i < 3) v[5:3] = i[2:0];
			run(v, $urandom, 1'b0);
			run(v, $urandom, 1'b1);
		end
		give_verdict;
	end
	initial begin
		repeat (6000) @(posedge clk);
		bad_count = bad_count + 1;
		give_verdict;
	end
endmodule // testbench

/* File: verilog/strap_capture.v */
`timescale 1ns/1ps
`include "strap_capture_regs.vh"
module strap_capture #(
	parameter DS_PORTS     = 3,
	parameter WARM_RST_CYC = `WARM_RST_CYC
) (
	input  wire                 CLK_I, // Core clock from the PLL
	input  wire                 SYS_RST_I,
	input  wire                 FUNDAMENTAL_RESET_PIN_N_I,
	input  wire                 COMMON_CLOCK_DOWNSTREAM_STRAP_I,
	input  wire                 COMMON_CLOCK_UPSTREAM_STRAP_I,
	input  wire                 HOLD_IN_RESET_STRAP_I,
	input  wire [`MODE_W-1:0]   SWITCH_OPERATING_MODE_STRAP_I,
	input  wire                 AUX_POWER_DISABLE_STRAP_N_I,
	input  wire                 EEPROM_WR_I,
	input  wire                 EEPROM_CCLK_DS_I,
	input  wire                 EEPROM_CCLK_US_I,
	input  wire                 EEPROM_HALT_I,
	input  wire                 EEPROM_APWR_N_I,
	input  wire                 EEPROM_DONE_I,
	input  wire                 SW_HALT_CLR_I,
	input  wire                 SW_FUNDAMENTAL_RESET_REQUEST_BIT_I,
	input  wire                 SW_SCLK_WR_I,
	input  wire [DS_PORTS:0]    SW_SCLK_DATA_I,
	output reg  [`STS_W-1:0]    SWITCH_STATUS_O,
	output reg  [DS_PORTS:0]    SLOT_CLOCK_CFG_O,
	output reg                  HOLD_IN_RESET_CTL_O,
	output reg                  CORE_RESET_O,
	output reg                  SMBUS_MASTER_EN_O,
	output reg                  EEPROM_LOAD_EN_O,
	output reg                  MODE_RESERVED_O,
	output reg                  AUX_POWER_EN_O,
	output reg                  STICKY_CLEAR_O
);
	localparam ST_RESET = 2'h0;
	localparam ST_LOAD  = 2'h1;
	localparam ST_HALT  = 2'h2;
	localparam ST_RUN   = 2'h3;
	localparam CNT_W    = 16;

	////////////////////////////////////////////////////////////////////////
	wire [7:0] raw_vec;
	wire [7:0] sync_vec;
	assign raw_vec = {FUNDAMENTAL_RESET_PIN_N_I, AUX_POWER_DISABLE_STRAP_N_I,
		SWITCH_OPERATING_MODE_STRAP_I, HOLD_IN_RESET_STRAP_I,
		COMMON_CLOCK_UPSTREAM_STRAP_I, COMMON_CLOCK_DOWNSTREAM_STRAP_I};

	strap_sync #(.W(8)) u_sync (
		.clk_i  (CLK_I),
		.rst_i  (SYS_RST_I),
		.async_i(raw_vec),
		.sync_o (sync_vec)
	);

	wire pin_n = sync_vec[7];

	function mode_is_eeprom;
		input [`MODE_W-1:0] m;
		begin
			mode_is_eeprom = (m == `MODE_EEPROM);
		end
	endfunction

	function mode_is_reserved;
		input [`MODE_W-1:0] m;
		begin
			mode_is_reserved = (m != `MODE_NORMAL) && (m != `MODE_EEPROM);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	reg              pin_n_ff;
	reg [6:0]        strap_ff;
	reg [6:0]        eff_ff;
	reg [1:0]        state_ff;
	reg [CNT_W-1:0]  warm_cnt_ff;
	reg              halt_ff;
	reg [1:0]        nxt_state;
	reg [6:0]        nxt_eff;
	reg              nxt_halt;

	wire pin_release = pin_n & ~pin_n_ff;
	wire pin_assert  = ~pin_n;
	wire warm_busy   = (warm_cnt_ff != {CNT_W{1'b0}});
	wire [`MODE_W-1:0] mode = strap_ff[5:3];

	// Sampled straps: only at pin release, otherwise held
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			pin_n_ff <= 1'b0;
			strap_ff <= 7'h00;
		end else begin
			pin_n_ff <= pin_n;
			if (pin_release) begin
				strap_ff <= sync_vec[6:0];
			end
			// Fundamental_reset_request_bit-started resets keep strap_ff as is
		end
	end

	// Reset request counter for warm reset from software
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			warm_cnt_ff <= {CNT_W{1'b0}};
		end else if (SW_FUNDAMENTAL_RESET_REQUEST_BIT_I && state_ff != ST_RESET) begin
			warm_cnt_ff <= WARM_RST_CYC[CNT_W-1:0];
		end else if (warm_busy) begin
			warm_cnt_ff <= warm_cnt_ff - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Held in reset on the capture edge too, else the stale vector is taken
	wire hold_reset = pin_assert || pin_release || warm_busy;

	// Sequencer next state; pin dominates all states, a warm request all but ST_RESET
	always @* begin
		nxt_state = state_ff;
		nxt_eff   = eff_ff;
		nxt_halt  = halt_ff;
		if (hold_reset) begin
			nxt_state = ST_RESET;
		end else begin
			case (state_ff)
				ST_RESET: begin
					// Latched or reused straps become working values
					nxt_eff   = strap_ff;
					nxt_halt  = strap_ff[`STS_HALT];
					nxt_state = mode_is_eeprom(mode) ? ST_LOAD : ST_HALT;
				end
				ST_LOAD: begin
					if (EEPROM_WR_I) begin
						// Mode bits never overridden
						nxt_eff[`STS_CCLK_DS] = EEPROM_CCLK_DS_I;
						nxt_eff[`STS_CCLK_US] = EEPROM_CCLK_US_I;
						nxt_eff[`STS_APWR_N]  = EEPROM_APWR_N_I;
						nxt_halt              = EEPROM_HALT_I;
					end
					if (EEPROM_DONE_I) begin
						nxt_state = ST_HALT;
					end
				end
				ST_HALT: begin
					if (SW_HALT_CLR_I) begin
						nxt_halt = 1'b0;
					end
					if (!halt_ff || SW_HALT_CLR_I) begin
						nxt_state = ST_RUN;
					end
				end
				ST_RUN: begin
					nxt_state = ST_RUN;
				end
				default: begin
					nxt_state = ST_RESET;
				end
			endcase
		end
	end

	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			state_ff <= ST_RESET;
			eff_ff   <= 7'h00;
			halt_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			eff_ff   <= nxt_eff;
			halt_ff  <= nxt_halt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slot clock bits: seeded every cycle in load and halt, then software owned
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			SLOT_CLOCK_CFG_O <= {(DS_PORTS+1){1'b0}};
		end else if (state_ff == ST_LOAD || state_ff == ST_HALT) begin
			// Reseeded until run so loader overrides land as well
			SLOT_CLOCK_CFG_O <= {{DS_PORTS{eff_ff[`STS_CCLK_DS]}},
				eff_ff[`STS_CCLK_US]};
		end else if (SW_SCLK_WR_I) begin
			SLOT_CLOCK_CFG_O <= SW_SCLK_DATA_I;
		end
	end

	// Outputs registered
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			SWITCH_STATUS_O     <= 7'h00;
			HOLD_IN_RESET_CTL_O <= 1'b0;
			CORE_RESET_O        <= 1'b1;
			SMBUS_MASTER_EN_O   <= 1'b0;
			EEPROM_LOAD_EN_O    <= 1'b0;
			MODE_RESERVED_O     <= 1'b0;
			AUX_POWER_EN_O      <= 1'b0;
			STICKY_CLEAR_O      <= 1'b0;
		end else begin
			SWITCH_STATUS_O     <= strap_ff;
			HOLD_IN_RESET_CTL_O <= halt_ff;
			CORE_RESET_O        <= (state_ff != ST_RUN);
			SMBUS_MASTER_EN_O   <= (state_ff == ST_HALT) || (state_ff == ST_RUN)
				|| (state_ff == ST_LOAD);
			EEPROM_LOAD_EN_O    <= (state_ff == ST_LOAD);
			MODE_RESERVED_O     <= mode_is_reserved(mode);
			AUX_POWER_EN_O      <= eff_ff[`STS_APWR_N] && (state_ff == ST_RUN);
			STICKY_CLEAR_O      <= !eff_ff[`STS_APWR_N] && (state_ff != ST_RUN
				|| !AUX_POWER_EN_O);
		end
	end
endmodule // strap_capture

/* File: verilog/strap_capture_regs.vh */
`ifndef STRAP_CAPTURE_REGS_VH
`define STRAP_CAPTURE_REGS_VH
`define MODE_W          3
`define MODE_NORMAL     3'h0
`define MODE_EEPROM     3'h1
`define STS_W           7
`define STS_CCLK_DS     0
`define STS_CCLK_US     1
`define STS_HALT        2
`define STS_MODE_LO     3
`define STS_APWR_N      6
`define WARM_RST_NS     100
`define CLK_PERIOD_NS   5
`define WARM_RST_CYC    ((`WARM_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: verilog/strap_sync.v */
`timescale 1ns/1ps
`include "strap_capture_regs.vh"
module strap_sync #(
	parameter W = 8
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;
	// Two stages; first stage read only by the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end
	assign sync_o = sync_ff;
endmodule // strap_sync
